// file: hdl/ddswf_pkg.sv
// Purpose: Shared constants and types for the synthesizer write port and frequency select logic
// Assumes: Single 50 MHz master clock; all pins synchronous to it
// Notes: Address map places both frequency words in halves, then four phase offsets
//
// Functional notes
// - Output frequency is the selected word as a fraction of the clock, the accumulator adding once per cycle with ce high.
// - The accumulator is fed from freq_word_a or freq_word_b according to freq_reg_select.
// - freq_reg_select is sampled only on rising clock edges.
// - Write data is captured at the rising edge of the active-low write strobe.
// - Captured data moves into its destination register on a later clock edge, not at the strobe edge.
// - A strobe rise before a clock edge is captured on that edge and loads on the edge after it.
// - The three address bits pick the destination register of a write.
// - A sixteen-bit parallel data bus carries the register contents.
// - Two phase select inputs, sampled on clock edges, pick one of four phase offsets added after the accumulator.
// - The active-low reset clears the accumulator to zero, the midscale point.
package ddswf_pkg;

  // ---------------------------------------------------------------
  // Widths and map
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 12;

  localparam logic [ADDR_W-1:0] ADDR_FREQ_A_LO = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_A_HI = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_B_LO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_FREQ_B_HI = 3'h3;
  localparam int ADDR_PHASE_BIT = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [FREQ_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 12'h000;
  localparam logic STROBE_IDLE = 1'b1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ddswf_wreq_t;

endpackage : ddswf_pkg

// file: hdl/ddswf_wr_capture.sv
// Purpose: Catch a host write at the strobe rising edge and flag it for loading
// Assumes: Strobe, address and data synchronous to clk
// Notes: loadDue lasts one enabled cycle, held request stays until the next write
module ddswf_wr_capture
  import ddswf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] reg_addr_bits,
  input wire logic [DATA_W-1:0] write_data_bits,
  output ddswf_wreq_t held,
  output logic loadDue
);

  logic strobePrev;
  logic strobeRise;

  // ---------------------------------------------------------------
  // Strobe edge
  // ---------------------------------------------------------------
  assign strobeRise = !strobePrev && write_strobe_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strobePrev <= STROBE_IDLE;
    else if (ce)
      strobePrev <= write_strobe_n;
  end

  // ---------------------------------------------------------------
  // Capture and hold
  // ---------------------------------------------------------------
  // Holding both fields keeps a late address change from steering the load
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      held <= '0;
    else if (ce && strobeRise)
      held <= '{addr: reg_addr_bits, data: write_data_bits};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loadDue <= 1'b0;
    else if (ce)
      loadDue <= strobeRise;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_capture;
    @(posedge clk) disable iff (!rst_n)
    ce && strobeRise |=> held == {$past(reg_addr_bits), $past(write_data_bits)};
  endproperty
  a_capture: assert property (p_capture) else $error("write not captured at strobe rise");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    !(ce && strobeRise) |=> $stable(held);
  endproperty
  a_hold: assert property (p_hold) else $error("held write changed without strobe rise");

  property p_pend;
    @(posedge clk) disable iff (!rst_n)
    ce && strobeRise |=> (loadDue and (ce |=> !loadDue));
  endproperty
  a_pend: assert property (p_pend) else $error("load request not exactly one cycle after rise");

  c_write: cover property (@(posedge clk) disable iff (!rst_n) ce && strobeRise);

endmodule : ddswf_wr_capture

// file: hdl/ddswf_top.sv
// Purpose: Write port, frequency and phase selection and phase accumulator of the synthesizer
// Assumes: All inputs synchronous to clk; host obeys strobe and select timing
// Notes: phaseOut is the lookup address; the lookup table and converter sit elsewhere
module ddswf_top
  import ddswf_pkg::*;
#(
  parameter int PH_W = PHASE_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] reg_addr_bits,
  input wire logic [DATA_W-1:0] write_data_bits,
  input wire logic freq_reg_select,
  input wire logic phase_reg_select_lo,
  input wire logic phase_reg_select_hi,
  output logic [FREQ_W-1:0] freq_word_a,
  output logic [FREQ_W-1:0] freq_word_b,
  output logic [FREQ_W-1:0] accum,
  output logic [PH_W-1:0] phaseOut
);

  ddswf_wreq_t held;
  logic loadDue;
  logic freqSel;
  logic [1:0] phaseSel;
  logic [PH_W-1:0] phaseReg [4];
  logic [FREQ_W-1:0] selWord;
  logic [PH_W-1:0] accTop;

  // ---------------------------------------------------------------
  // Write capture
  // ---------------------------------------------------------------
  ddswf_wr_capture u_capture (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .write_strobe_n(write_strobe_n),
    .reg_addr_bits(reg_addr_bits),
    .write_data_bits(write_data_bits),
    .held(held),
    .loadDue(loadDue)
  );

  // ---------------------------------------------------------------
  // Destination registers
  // ---------------------------------------------------------------
  // Loading one edge after capture keeps the strobe off the register clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_word_a <= FREQ_RESET;
      freq_word_b <= FREQ_RESET;
    end
    else if (ce && loadDue)
    begin
      unique case (held.addr)
        ADDR_FREQ_A_LO: freq_word_a[DATA_W-1:0] <= held.data;
        ADDR_FREQ_A_HI: freq_word_a[FREQ_W-1:DATA_W] <= held.data;
        ADDR_FREQ_B_LO: freq_word_b[DATA_W-1:0] <= held.data;
        ADDR_FREQ_B_HI: freq_word_b[FREQ_W-1:DATA_W] <= held.data;
        default: ;
      endcase
    end
  end

  // Phase offsets keep only the low bits of the data bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        phaseReg[i] <= PHASE_RESET[PH_W-1:0];
    end
    else if (ce && loadDue && held.addr[ADDR_PHASE_BIT])
      phaseReg[held.addr[1:0]] <= held.data[PH_W-1:0];
  end

  // ---------------------------------------------------------------
  // Select sampling
  // ---------------------------------------------------------------
  // A select moving at the edge itself may land one cycle late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freqSel <= 1'b0;
      phaseSel <= 2'h0;
    end
    else if (ce)
    begin
      freqSel <= freq_reg_select;
      phaseSel <= {phase_reg_select_hi, phase_reg_select_lo};
    end
  end

  // ---------------------------------------------------------------
  // Accumulator and phase offset
  // ---------------------------------------------------------------
  assign selWord = freqSel ? freq_word_b : freq_word_a;
  assign accTop = accum[FREQ_W-1 -: PH_W];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      accum <= ACC_RESET;
    else if (ce)
      accum <= accum + selWord;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phaseOut <= PHASE_RESET[PH_W-1:0];
    else if (ce)
      phaseOut <= accTop + phaseReg[phaseSel];
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_acc_step;
    @(posedge clk) disable iff (!rst_n)
    ce |=> accum == $past(accum) + (($past(freqSel)) ? $past(freq_word_b) : $past(freq_word_a));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator did not add selected word");

  property p_acc_freeze;
    @(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(accum) && $stable(freqSel);
  endproperty
  a_acc_freeze: assert property (p_acc_freeze) else $error("state moved with enable low");

  property p_fsel;
    @(posedge clk) disable iff (!rst_n)
    ce ##1 ce |=> accum == $past(accum) + ($past(freq_reg_select, 2) ? $past(freq_word_b) : $past(freq_word_a));
  endproperty
  a_fsel: assert property (p_fsel) else $error("frequency select not taken from the sampled pin");

  property p_load_a_lo;
    @(posedge clk) disable iff (!rst_n)
    ce && loadDue && held.addr == ADDR_FREQ_A_LO |=> freq_word_a[DATA_W-1:0] == $past(held.data);
  endproperty
  a_load_a_lo: assert property (p_load_a_lo) else $error("low half of word a not loaded");

  property p_load_b_hi;
    @(posedge clk) disable iff (!rst_n)
    ce && loadDue && held.addr == ADDR_FREQ_B_HI |=> freq_word_b[FREQ_W-1:DATA_W] == $past(held.data);
  endproperty
  a_load_b_hi: assert property (p_load_b_hi) else $error("high half of word b not loaded");

  property p_no_load;
    @(posedge clk) disable iff (!rst_n)
    !(ce && loadDue) |=> $stable(freq_word_a) && $stable(freq_word_b);
  endproperty
  a_no_load: assert property (p_no_load) else $error("frequency word changed without a write");

  property p_strobe_to_load;
    @(posedge clk) disable iff (!rst_n)
    ce && $past(ce) && $rose(write_strobe_n) && reg_addr_bits == ADDR_FREQ_B_LO ##1 ce
      |=> freq_word_b[DATA_W-1:0] == $past(write_data_bits, 2);
  endproperty
  a_strobe_to_load: assert property (p_strobe_to_load) else $error("write not loaded on the edge after rise");

  property p_phase_load;
    @(posedge clk) disable iff (!rst_n)
    ce && loadDue && held.addr[ADDR_PHASE_BIT] |=> phaseReg[$past(held.addr[1:0])] == $past(held.data[PH_W-1:0]);
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("phase offset not loaded");

  property p_phase_out;
    @(posedge clk) disable iff (!rst_n)
    ce |=> phaseOut == $past(accTop) + $past(phaseReg[phaseSel]);
  endproperty
  a_phase_out: assert property (p_phase_out) else $error("phase output not accumulator plus offset");

  property p_psel;
    @(posedge clk) disable iff (!rst_n)
    ce |=> phaseSel == {$past(phase_reg_select_hi), $past(phase_reg_select_lo)};
  endproperty
  a_psel: assert property (p_psel) else $error("phase select not sampled on the edge");

  property p_load_a_hi;
    @(posedge clk) disable iff (!rst_n)
    ce && loadDue && held.addr == ADDR_FREQ_A_HI |=> freq_word_a[FREQ_W-1:DATA_W] == $past(held.data);
  endproperty
  a_load_a_hi: assert property (p_load_a_hi) else $error("high half of word a not loaded");

  property p_load_b_lo;
    @(posedge clk) disable iff (!rst_n)
    ce && loadDue && held.addr == ADDR_FREQ_B_LO |=> freq_word_b[DATA_W-1:0] == $past(held.data);
  endproperty
  a_load_b_lo: assert property (p_load_b_lo) else $error("low half of word b not loaded");

  // Halves load on their own, so a write must leave its partner half alone
  property p_half_only;
    @(posedge clk) disable iff (!rst_n)
    ce && loadDue && held.addr == ADDR_FREQ_A_LO
      |=> freq_word_a[FREQ_W-1:DATA_W] == $past(freq_word_a[FREQ_W-1:DATA_W]) && $stable(freq_word_b);
  endproperty
  a_half_only: assert property (p_half_only) else $error("write disturbed another register half");

  property p_phase_keep;
    @(posedge clk) disable iff (!rst_n)
    !(ce && loadDue && held.addr[ADDR_PHASE_BIT])
      |=> $stable(phaseReg[0]) && $stable(phaseReg[1]) && $stable(phaseReg[2]) && $stable(phaseReg[3]);
  endproperty
  a_phase_keep: assert property (p_phase_keep) else $error("phase offset changed without a write");

  property p_psel_freeze;
    @(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(phaseSel) && $stable(phaseOut);
  endproperty
  a_psel_freeze: assert property (p_psel_freeze) else $error("phase path moved with enable low");

  // No disable here: the check runs on the first edge after release
  property p_acc_clear;
    @(posedge clk)
    $rose(rst_n) |-> accum == ACC_RESET;
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared by reset");

  c_sel_b: cover property (@(posedge clk) disable iff (!rst_n) ce && freqSel && freq_word_b != FREQ_RESET);
  c_sel_switch: cover property (@(posedge clk) disable iff (!rst_n) ce && $changed(freqSel));
  c_phase_wr: cover property (@(posedge clk) disable iff (!rst_n) ce && loadDue && held.addr[ADDR_PHASE_BIT]);
  c_wrap: cover property (@(posedge clk) disable iff (!rst_n) ce && accum < $past(accum));

endmodule : ddswf_top

// file: verification/ddswf_host_model.sv
// Purpose: Host side of the parallel write port
// Assumes: Caller enters doWrite 1 ns after a rising clock edge
// Notes: After the hold runs out address and data show their inverse, unless more is set
module ddswf_host_model
  import ddswf_pkg::*;
(
  input wire logic clk,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] reg_addr_bits,
  output logic [DATA_W-1:0] write_data_bits
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    write_strobe_n = STROBE_IDLE;
    reg_addr_bits = '0;
    write_data_bits = '0;
  end

  // ---------------------------------------------------------------
  // One write; more keeps lines for a back-to-back write
  // ---------------------------------------------------------------
  task automatic doWrite(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data, input int lowCycles,
                         input bit more);
    write_strobe_n = 1'b0;
    reg_addr_bits = addr;
    write_data_bits = data;
    repeat (lowCycles) @(posedge clk);
    #1;
    write_strobe_n = 1'b1;
    @(posedge clk);
    #1;
    if (!more)
    begin
      // Stale lines would hide a late sample
      reg_addr_bits = ~addr;
      write_data_bits = ~data;
      // One idle edge, so the next write never reassigns these lines in the same step
      @(posedge clk);
      #1;
    end
  endtask : doWrite
endmodule : ddswf_host_model

// file: verification/ddswf_top_tb.sv
// Purpose: Self-checking bench of the write port and accumulator
// Assumes: Inputs change 1 ns after the rising edge
// Notes: A cycle model in the bench mirrors every output
module ddswf_top_tb
  import ddswf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 12;
  logic clk, rst_n, ce, freq_reg_select, phase_reg_select_lo, phase_reg_select_hi, write_strobe_n;
  logic [ADDR_W-1:0] reg_addr_bits;
  logic [DATA_W-1:0] write_data_bits;
  logic [FREQ_W-1:0] freq_word_a, freq_word_b, accum, mFa, mFb, mAcc, r;
  logic [PW-1:0] phaseOut, mPh;
  logic [PW-1:0] mOff [4];
  logic mPrev, mLoad, mFsel;
  logic [1:0] mPsel;
  ddswf_wreq_t mHeld;
  logic [31:0] seed = 32'h5d3fabf0;
  int n_fail = 0;
  int checks_done = 0;

  ddswf_top #(.PH_W(PW)) u_ddswf_top (.clk(clk), .rst_n(rst_n), .ce(ce), .write_strobe_n(write_strobe_n),
    .reg_addr_bits(reg_addr_bits), .write_data_bits(write_data_bits), .freq_reg_select(freq_reg_select),
    .phase_reg_select_lo(phase_reg_select_lo), .phase_reg_select_hi(phase_reg_select_hi),
    .freq_word_a(freq_word_a), .freq_word_b(freq_word_b), .accum(accum), .phaseOut(phaseOut));
  ddswf_host_model u_ddswf_host_model (.clk(clk), .write_strobe_n(write_strobe_n),
    .reg_addr_bits(reg_addr_bits), .write_data_bits(write_data_bits));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic check(input logic [FREQ_W-1:0] got, input logic [FREQ_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // Cycle model
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {mFa, mFb, mAcc, mPh, mLoad, mFsel, mPsel, mHeld} = '0;
      mOff = '{default: '0};
      mPrev = STROBE_IDLE;
    end
    else if (ce)
    begin
      mPh = mAcc[FREQ_W-1 -: PW] + mOff[mPsel];
      mAcc = mAcc + (mFsel ? mFb : mFa);
      if (mLoad)
        case (mHeld.addr)
          ADDR_FREQ_A_LO: mFa[15:0] = mHeld.data;
          ADDR_FREQ_A_HI: mFa[31:16] = mHeld.data;
          ADDR_FREQ_B_LO: mFb[15:0] = mHeld.data;
          ADDR_FREQ_B_HI: mFb[31:16] = mHeld.data;
          default: mOff[mHeld.addr[1:0]] = mHeld.data[PW-1:0];
        endcase
      mLoad = !mPrev && write_strobe_n;
      if (mLoad)
        mHeld = '{reg_addr_bits, write_data_bits};
      mPrev = write_strobe_n;
      mFsel = freq_reg_select;
      mPsel = {phase_reg_select_hi, phase_reg_select_lo};
    end
  end

  always @(negedge clk)
  begin
    check(freq_word_a, rst_n ? mFa : '0);
    check(freq_word_b, rst_n ? mFb : '0);
    check(accum, rst_n ? mAcc : '0);
    check(FREQ_W'(phaseOut), rst_n ? FREQ_W'(mPh) : '0);
  end

  // ---------------------------------------------------------------
  // Clock, stimulus, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    {rst_n, freq_reg_select, phase_reg_select_lo, phase_reg_select_hi} = '0;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
      u_ddswf_host_model.doWrite(i[2:0], 16'(xorshift() >> 16), 1, i < 7);
    for (int i = 0; i < 8; i++)
    begin
      {phase_reg_select_hi, phase_reg_select_lo, freq_reg_select} = i[2:0];
      repeat (3) @(posedge clk);
      #1;
    end
    repeat (400)
    begin
      r = xorshift();
      ce = r[0] | r[1];
      {phase_reg_select_hi, phase_reg_select_lo, freq_reg_select} = r[4:2];
      u_ddswf_host_model.doWrite(r[7:5], r[31:16], 1 + r[9:8], r[10]);
      if (r[15:11] == 5'h1f)
      begin
        // Mid-run reset, asserted off the edge
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
      end
    end
    repeat (4) @(posedge clk);
    print_verdict();
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    n_fail++;
    $display("FAIL %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : ddswf_top_tb
